// File: psc_host.sv
`default_nettype none

module psc_host (
    input wire logic clk,
    input wire logic sdo,
    output logic sck,
    output logic sdi,
    output logic le
);
    timeunit 1ns;
    timeprecision 1ps;
    // Serial clock stands low and the latch high outside frames.
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        le = 1'b1;
    end
    // Half a serial period, kept long because the pins are synchronised.
    task automatic hp();
        repeat (8) @(posedge clk);
        #1;
    endtask
    // Sends n bits, MSB first; read data is caught just before the rise of each of the low 27 bits.
    task automatic frame(input logic [31:0] wd, input int n, output logic [26:0] rd);
        rd = '0;
        le = 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            sdi = wd[i];
            hp();
            if (i < 27) rd[i] = sdo;
            sck = 1'b1;
            hp();
            sck = 1'b0;
        end
        hp();
        le = 1'b1;
        // A released data line shows the inverse, never the last bit.
        sdi = ~sdi;
        hp();
        hp();
    endtask
endmodule

`default_nettype wire

// File: psc_pkg.sv
`default_nettype none

package psc_pkg;

    // ------------------------------------------------------------------
    // Serial frame layout.
    // ------------------------------------------------------------------
    localparam int FRAME_BITS = 32;
    localparam int DATA_BITS = 27;
    localparam int ADDR_BITS = 4;

    // ------------------------------------------------------------------
    // Register addresses.
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_MASTER = 4'h0;
    localparam logic [3:0] ADDR_FRACTION_NUMERATOR_RF1 = 4'h1;
    localparam logic [3:0] ADDR_MOD_RF2 = 4'h2;
    localparam logic [3:0] ADDR_REFDIV = 4'h3;
    localparam logic [3:0] ADDR_LOCKCFG = 4'h4;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int POS_SHADOW = 26;
    localparam int POS_OUT1_PD = 24;
    localparam int POS_MAN_CAL = 23;
    localparam int POS_PLL_HALF = 22;
    localparam int POS_OUT1_DIV = 21;
    localparam int POS_MOD_CLK_OFF = 25;
    localparam int POS_OUT2_PD = 21;
    localparam int POS_CHIP_PD = 25;
    localparam int POS_LEAK_X2 = 24;
    localparam int POS_LEAK_HI = 23;
    localparam int POS_LEAK_LO = 19;
    localparam int POS_LEAK_DIR = 18;
    localparam int POS_DSPLIT = 17;
    localparam int POS_DMODE_HI = 16;
    localparam int POS_DMODE_LO = 15;
    localparam int POS_RPATH_HI = 14;
    localparam int POS_RPATH_LO = 13;
    localparam int POS_EXT_OSC = 19;
    localparam int POS_AMP_HI = 17;
    localparam int POS_AMP_LO = 15;
    localparam int POS_CAL_MODE = 12;
    localparam int POS_GCOMP_OFF = 11;
    localparam int POS_RBUF_HI = 9;
    localparam int POS_RBUF_LO = 8;
    localparam int POS_MUTE = 7;
    localparam int POS_LD_LOW = 6;
    localparam int POS_WIN_HI = 5;
    localparam int POS_WIN_LO = 3;
    localparam int POS_CNT_HI = 2;
    localparam int POS_CNT_LO = 0;
    localparam int POS_DEL_HI = 20;
    localparam int POS_DEL_LO = 19;

    // ------------------------------------------------------------------
    // Reset values and timing.
    // ------------------------------------------------------------------
    localparam logic [26:0] RESET_DATA = 27'h0000000;
    localparam int LEAK_STEP_UA = 10;
    localparam int WIN_STEP_NS = 2;

    // Decoded delay modes: none, VCO, reference, reserved.
    typedef enum logic [1:0] {
        PSC_DEL_NONE = 2'b00,
        PSC_DEL_VCO = 2'b01,
        PSC_DEL_REF = 2'b10,
        PSC_DEL_RSVD = 2'b11
    } psc_delay_t;

    // Analog control bundle handed to the synthesizer core.
    typedef struct packed {
        logic [20:0] numerator;
        logic [20:0] modulus;
        logic [12:0] ref_div;
        logic [1:0] ref_path;
        logic [1:0] ref_buf;
        logic [9:0] leak_ua;
        logic leak_source;
        logic [1:0] split_level;
        logic vco_delay;
        logic ref_delay;
        logic pll_half;
        logic out1_div;
        logic [2:0] amplitude;
        logic cal_mode;
    } psc_ctrl_t;

endpackage

`default_nettype wire

// File: psc_regs.sv
// ----------------------------------------------------------------------
// Functional notes
// RULE1 - Bit 26 set: shadow until master write
// RULE2 - Numerator bits 20:0, below modulus
// RULE3 - Host keeps modulus within 2..2097151
// RULE4 - Bit 24 zero enables first output
// RULE5 - Manual calibration uses selections, inhibits autocal
// RULE6 - Bit 22 selects VCO halved to divider
// RULE7 - Host powers down second output
// RULE8 - Host writes zero to reserved bits
// RULE9 - Power-down bit switches off internal blocks; the code leaves gain_comp_enable ungated
// RULE10 - Leakage equals code times 10/20 uA
// RULE11 - Delay mode: none, VCO, reference, reserved
// RULE12 - Down-split current follows master delay code
// RULE13 - Reference path: direct, double, half, quarter
// RULE14 - Reference divider 13 bits, 1..8191
// RULE15 - External oscillator replaces internal VCOs
// RULE16 - Host limits amplitude at 3.3 V
// RULE17 - Host sets calibrator mode by supply
// RULE18 - Gain compensation unless disable bit set
// RULE19 - Reference buffer mode decode, 00 reserved
// RULE20 - Mute outputs while unlocked if enabled
// RULE21 - Lock indicator polarity from bit 6
// RULE22 - Lock window 2 ns to 16 ns
// RULE23 - Lock count code maps 4..4096 cycles
// RULE24 - Master write transfers shadows, starts calibration
// RULE25 - 32-bit frame: R/W, address, 27 data
// RULE26 - Count in-window cycles; clear outside; lock
// ----------------------------------------------------------------------
`default_nettype none

module psc_regs
    import psc_pkg::*;
#(
    parameter int CNT_W = 13
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_clk,
    input wire logic spi_data_in,
    input wire logic spi_latch,
    input wire logic pfd_tick,
    input wire logic [3:0] phase_err_ns,
    output logic spi_data_out,
    output logic spi_data_oe,
    output logic lock_indicator,
    output logic out1_enable,
    output logic out2_enable,
    output logic chip_power_down,
    output logic auto_cal_enable,
    output logic cal_start,
    output logic internal_vco_enable,
    output logic ext_buffer_enable,
    output logic gain_comp_enable,
    output logic down_split_on,
    output psc_ctrl_t ctrl
);

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------
    // Three stages per pin; a change counts once stages two and three agree.
    logic [2:0] sck_s_reg, sdi_s_reg, le_s_reg;
    logic sck_q_reg, le_q_reg;

    // Synchroniser chain; the first stage feeds only the second.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_s_reg <= 3'h0;
            sdi_s_reg <= 3'h0;
            le_s_reg <= 3'h7;
        end else begin
            sck_s_reg <= {sck_s_reg[1:0], spi_clk};
            sdi_s_reg <= {sdi_s_reg[1:0], spi_data_in};
            le_s_reg <= {le_s_reg[1:0], spi_latch};
        end
    end

    // Filtered levels: updated only when stages two and three agree.
    logic sck_q_next, le_q_next;
    always_comb begin
        sck_q_next = (sck_s_reg[1] == sck_s_reg[2]) ? sck_s_reg[2] : sck_q_reg;
        le_q_next = (le_s_reg[1] == le_s_reg[2]) ? le_s_reg[2] : le_q_reg;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_q_reg <= 1'b0;
            le_q_reg <= 1'b1;
        end else begin
            sck_q_reg <= sck_q_next;
            le_q_reg <= le_q_next;
        end
    end

    wire sck_rise = sck_q_next & ~sck_q_reg;
    wire sck_fall = ~sck_q_next & sck_q_reg;
    wire le_rise = le_q_next & ~le_q_reg;
    wire le_fall = ~le_q_next & le_q_reg;

    // ------------------------------------------------------------------
    // Serial frame engine.
    // ------------------------------------------------------------------
    // Frame starts when the latch falls and is committed when it rises after 32 bits.
    logic [31:0] shift_reg, shift_next;
    logic [5:0] bits_reg, bits_next;
    logic [26:0] rd_data_reg, rd_data_next;
    logic rd_act_reg, rd_act_next;
    logic sdo_reg, sdo_next;
    logic [26:0] act_reg [0:4];
    logic [26:0] act_next [0:4];
    logic [26:0] shd_reg [1:3];
    logic [26:0] shd_next [1:3];
    logic [3:1] pend_reg, pend_next;
    logic cal_reg, cal_next;

    // Decode a committed frame address into a register select.
    function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
        hit = (a == want);
    endfunction

    wire frame_done = le_rise && (bits_reg == 6'(FRAME_BITS));
    wire is_read = shift_reg[31];
    wire [3:0] f_addr = shift_reg[30:27];
    wire [26:0] f_data = shift_reg[26:0];

    // Next state of the frame engine and the register bank.
    always_comb begin
        shift_next = shift_reg;
        bits_next = bits_reg;
        rd_data_next = rd_data_reg;
        rd_act_next = rd_act_reg;
        sdo_next = sdo_reg;
        cal_next = 1'b0;
        pend_next = pend_reg;
        for (int i = 0; i < 5; i++) begin
            act_next[i] = act_reg[i];
        end
        for (int i = 1; i < 4; i++) begin
            shd_next[i] = shd_reg[i];
        end
        if (le_fall) begin
            // A new frame always restarts the bit count.
            bits_next = 6'h00;
            rd_act_next = 1'b0;
        end else if (!le_q_reg && sck_rise && bits_reg < 6'(FRAME_BITS)) begin
            shift_next = {shift_reg[30:0], sdi_s_reg[2]}; // [RULE25]
            bits_next = bits_reg + 6'h01;
            if (bits_reg == 6'(ADDR_BITS) && shift_reg[ADDR_BITS - 1]) begin
                // Read: the select bit sits three places up once three address bits are in,
                // and the fourth address bit is the one arriving now.
                rd_act_next = 1'b1;
                rd_data_next = 27'h0;
                for (int i = 0; i < 5; i++) begin
                    if (hit({shift_reg[2:0], sdi_s_reg[2]}, 4'(i))) begin
                        rd_data_next = act_reg[i];
                    end
                end
            end
        end else if (rd_act_reg && sck_fall) begin
            sdo_next = rd_data_reg[26];
            rd_data_next = {rd_data_reg[25:0], 1'b0};
        end
        if (frame_done && !is_read) begin
            if (hit(f_addr, ADDR_MASTER)) begin
                act_next[0] = f_data;
                // Shadowed contents go live and calibration restarts.
                for (int i = 1; i < 4; i++) begin
                    if (pend_reg[i]) begin
                        act_next[i] = shd_reg[i]; // [RULE24]
                    end
                end
                pend_next = 3'h0;
                cal_next = 1'b1; // [RULE24]
            end else if (hit(f_addr, ADDR_LOCKCFG)) begin
                act_next[4] = f_data;
            end else begin
                for (int i = 1; i < 4; i++) begin
                    if (hit(f_addr, 4'(i))) begin
                        if (f_data[POS_SHADOW]) begin
                            shd_next[i] = f_data; // [RULE1]
                            pend_next[i] = 1'b1;
                        end else begin
                            act_next[i] = f_data;
                        end
                    end
                end
            end
        end
        if (le_rise) begin
            rd_act_next = 1'b0;
        end
    end

    // Frame engine and register bank storage.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= 32'h0;
            bits_reg <= 6'h00;
            rd_data_reg <= 27'h0;
            rd_act_reg <= 1'b0;
            sdo_reg <= 1'b0;
            cal_reg <= 1'b0;
            pend_reg <= 3'h0;
            for (int i = 0; i < 5; i++) begin
                act_reg[i] <= RESET_DATA;
            end
            for (int i = 1; i < 4; i++) begin
                shd_reg[i] <= RESET_DATA;
            end
        end else begin
            shift_reg <= shift_next;
            bits_reg <= bits_next;
            rd_data_reg <= rd_data_next;
            rd_act_reg <= rd_act_next;
            sdo_reg <= sdo_next;
            cal_reg <= cal_next;
            pend_reg <= pend_next;
            for (int i = 0; i < 5; i++) begin
                act_reg[i] <= act_next[i];
            end
            for (int i = 1; i < 4; i++) begin
                shd_reg[i] <= shd_next[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Lock detector.
    // ------------------------------------------------------------------
    // Counts consecutive in-window detector cycles; ticks are one-cycle enables.
    logic [CNT_W-1:0] lk_cnt_reg, lk_cnt_next;
    logic locked_reg, locked_next;
    logic [CNT_W-1:0] target;
    logic [4:0] window_ns; // Five bits, because the widest window is 16 ns.
    // Power-down level, shared by the lock detector and the output stage.
    wire chip_pd_w = act_reg[3][POS_CHIP_PD];

    // Window and count target derived from the lock configuration.
    always_comb begin
        window_ns = 5'((int'(act_reg[4][POS_WIN_HI:POS_WIN_LO]) + 1) * WIN_STEP_NS); // [RULE22]
        case (act_reg[4][POS_CNT_HI:POS_CNT_LO]) // [RULE23]
            3'h0: target = CNT_W'(4);
            3'h1: target = CNT_W'(8);
            3'h2: target = CNT_W'(16);
            3'h3: target = CNT_W'(64);
            3'h4: target = CNT_W'(256);
            3'h5: target = CNT_W'(1024);
            3'h6: target = CNT_W'(2048);
            default: target = CNT_W'(4096);
        endcase
    end

    // Next count and lock flag.
    // Power-down drops lock at once, without waiting for a detector tick,
    // because a sleeping loop delivers no ticks that could clear it.
    always_comb begin
        lk_cnt_next = lk_cnt_reg;
        locked_next = locked_reg;
        if (chip_pd_w) begin
            lk_cnt_next = '0; // [RULE9]
            locked_next = 1'b0;
        end else if (pfd_tick) begin
            if ({1'b0, phase_err_ns} > window_ns) begin
                lk_cnt_next = '0; // [RULE26]
                locked_next = 1'b0;
            end else if (lk_cnt_reg < target) begin
                lk_cnt_next = lk_cnt_reg + CNT_W'(1);
            end else begin
                locked_next = 1'b1; // [RULE26]
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_cnt_reg <= '0;
            locked_reg <= 1'b0;
        end else begin
            lk_cnt_reg <= lk_cnt_next;
            locked_reg <= locked_next;
        end
    end

    // ------------------------------------------------------------------
    // Control outputs.
    // ------------------------------------------------------------------
    wire mute_w = act_reg[4][POS_MUTE] & ~locked_reg; // [RULE20]
    psc_ctrl_t ctrl_next;

    // Decoded control bundle for the analog core.
    always_comb begin
        ctrl_next.numerator = act_reg[1][20:0]; // [RULE2]
        ctrl_next.modulus = act_reg[2][20:0];
        ctrl_next.ref_div = act_reg[3][12:0]; // [RULE14]
        ctrl_next.ref_path = act_reg[3][POS_RPATH_HI:POS_RPATH_LO]; // [RULE13]
        ctrl_next.ref_buf = act_reg[4][POS_RBUF_HI:POS_RBUF_LO]; // [RULE19]
        ctrl_next.leak_ua = 10'(int'(act_reg[3][POS_LEAK_HI:POS_LEAK_LO]) * LEAK_STEP_UA
                            * (act_reg[3][POS_LEAK_X2] ? 2 : 1)); // [RULE10]
        ctrl_next.leak_source = act_reg[3][POS_LEAK_DIR]; // [RULE10]
        ctrl_next.split_level = act_reg[3][POS_DSPLIT] ? act_reg[0][POS_DEL_HI:POS_DEL_LO] : 2'h0; // [RULE12]
        ctrl_next.vco_delay = psc_delay_t'(act_reg[3][POS_DMODE_HI:POS_DMODE_LO]) == PSC_DEL_VCO; // [RULE11]
        ctrl_next.ref_delay = psc_delay_t'(act_reg[3][POS_DMODE_HI:POS_DMODE_LO]) == PSC_DEL_REF; // [RULE11]
        ctrl_next.pll_half = act_reg[1][POS_PLL_HALF]; // [RULE6]
        ctrl_next.out1_div = act_reg[1][POS_OUT1_DIV];
        ctrl_next.amplitude = act_reg[4][POS_AMP_HI:POS_AMP_LO];
        ctrl_next.cal_mode = act_reg[4][POS_CAL_MODE];
    end

    // Output registers; power-down clears every enable except gain_comp_enable.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= '0;
            spi_data_out <= 1'b0;
            spi_data_oe <= 1'b0;
            lock_indicator <= 1'b0;
            out1_enable <= 1'b0;
            out2_enable <= 1'b0;
            chip_power_down <= 1'b0;
            auto_cal_enable <= 1'b0;
            cal_start <= 1'b0;
            internal_vco_enable <= 1'b0;
            ext_buffer_enable <= 1'b0;
            gain_comp_enable <= 1'b0;
            down_split_on <= 1'b0;
        end else begin
            ctrl <= ctrl_next;
            spi_data_out <= sdo_reg;
            spi_data_oe <= rd_act_reg;
            lock_indicator <= locked_reg ^ act_reg[4][POS_LD_LOW]; // [RULE21]
            out1_enable <= ~act_reg[1][POS_OUT1_PD] & ~mute_w & ~chip_pd_w; // [RULE4] [RULE9]
            out2_enable <= ~act_reg[2][POS_OUT2_PD] & ~mute_w & ~chip_pd_w;
            chip_power_down <= chip_pd_w; // [RULE9]
            auto_cal_enable <= ~act_reg[1][POS_MAN_CAL] & ~chip_pd_w; // [RULE5]
            cal_start <= cal_reg & ~act_reg[1][POS_MAN_CAL] & ~chip_pd_w; // [RULE5] [RULE24]
            internal_vco_enable <= ~act_reg[4][POS_EXT_OSC] & ~chip_pd_w; // [RULE15]
            ext_buffer_enable <= act_reg[4][POS_EXT_OSC] & ~chip_pd_w; // [RULE15]
            gain_comp_enable <= ~act_reg[4][POS_GCOMP_OFF]; // [RULE18]
            down_split_on <= act_reg[3][POS_DSPLIT] & ~chip_pd_w; // [RULE12]
        end
    end

endmodule

`default_nettype wire

// File: psc_regs_asserts.sv
`default_nettype none

module psc_regs_asserts
    import psc_pkg::*;
#(
    parameter int CNT_W = 13
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_clk,
    input wire logic spi_data_in,
    input wire logic spi_latch,
    input wire logic pfd_tick,
    input wire logic [3:0] phase_err_ns,
    input wire logic spi_data_out,
    input wire logic spi_data_oe,
    input wire logic lock_indicator,
    input wire logic out1_enable,
    input wire logic out2_enable,
    input wire logic chip_power_down,
    input wire logic auto_cal_enable,
    input wire logic cal_start,
    input wire logic internal_vco_enable,
    input wire logic ext_buffer_enable,
    input wire logic gain_comp_enable,
    input wire logic down_split_on,
    input wire psc_ctrl_t ctrl
);
    // ------------------------------------------------------------
    // One clock domain, so clocking and reset are shared.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_cal_one_cycle: assert property (cal_start |=> !cal_start)
        else $error("calibration start wider than one cycle");
    a_pd_outputs_off: assert property (chip_power_down && $past(chip_power_down)
        |-> !out1_enable && !out2_enable)
        else $error("output enabled while powered down");
    a_pd_vco_off: assert property (chip_power_down && $past(chip_power_down) |-> !internal_vco_enable)
        else $error("oscillator on while powered down");
    a_vco_exclusive: assert property (ext_buffer_enable |-> !internal_vco_enable)
        else $error("external and internal oscillators both on");
    a_leak_scale: assert property (ctrl.leak_ua <= 10'h26c && ctrl.leak_ua % 10 == 0)
        else $error("leakage current off the step grid");
    a_delay_exclusive: assert property (!(ctrl.vco_delay && ctrl.ref_delay))
        else $error("both detector inputs delayed");
    a_cal_needs_auto: assert property (cal_start |-> auto_cal_enable || $past(auto_cal_enable))
        else $error("calibration started in manual mode");
    // A latch held high this long means no frame is landing.
    a_ctrl_quiet: assert property (spi_latch [*8] |=> $stable(ctrl))
        else $error("control bundle moved with no frame");
    a_oe_idle: assert property (spi_latch [*8] |-> !spi_data_oe)
        else $error("read driver on outside a frame");
    a_oe_in_frame: assert property ($rose(spi_data_oe) |-> !spi_latch)
        else $error("read driver turned on with latch high");

    c_cal: cover property (cal_start);
    c_lock: cover property ($rose(lock_indicator));
    c_read: cover property ($rose(spi_data_oe));
endmodule

bind psc_regs psc_regs_asserts #(.CNT_W(CNT_W)) u_psc_chk (
    .clk(clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_data_in(spi_data_in), .spi_latch(spi_latch),
    .pfd_tick(pfd_tick), .phase_err_ns(phase_err_ns), .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe),
    .lock_indicator(lock_indicator), .out1_enable(out1_enable), .out2_enable(out2_enable),
    .chip_power_down(chip_power_down), .auto_cal_enable(auto_cal_enable), .cal_start(cal_start),
    .internal_vco_enable(internal_vco_enable), .ext_buffer_enable(ext_buffer_enable),
    .gain_comp_enable(gain_comp_enable), .down_split_on(down_split_on), .ctrl(ctrl)
);

`default_nettype wire

// File: tb_psc_regs.sv
`default_nettype none

module tb_psc_regs
    import psc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst;
    logic pfd_tick = 1'b0;
    logic [3:0] phase_err_ns = 4'h0;
    logic sck, sdi, le, dout, oe, lk, cs;
    logic [7:0] en;
    psc_ctrl_t ctrl;
    // Reference model: active words, shadow words and pending flags.
    logic [26:0] m [0:4];
    logic [26:0] sh [1:3];
    logic [3:1] pend;
    logic locked;
    int cal_n = 0, cal_exp = 0, fail_count = 0, n_tests = 0;
    logic [31:0] seed = 32'ha25ba031;
    int tg [8] = '{4, 8, 16, 64, 256, 1024, 2048, 4096};

    always #5 clk = ~clk;

    psc_regs dut (
        .clk(clk), .sys_rst(sys_rst), .spi_clk(sck), .spi_data_in(sdi), .spi_latch(le),
        .pfd_tick(pfd_tick), .phase_err_ns(phase_err_ns), .spi_data_out(dout), .spi_data_oe(oe),
        .lock_indicator(lk), .out1_enable(en[7]), .out2_enable(en[6]), .chip_power_down(en[5]),
        .auto_cal_enable(en[4]), .cal_start(cs), .internal_vco_enable(en[3]),
        .ext_buffer_enable(en[2]), .gain_comp_enable(en[1]), .down_split_on(en[0]), .ctrl(ctrl)
    );
    // The read line is only meaningful while the device drives it.
    psc_host host (.clk(clk), .sdo(dout & oe), .sck(sck), .sdi(sdi), .le(le));

    // Counts calibration pulses seen on the port.
    always @(posedge clk) begin
        if (cs === 1'b1) cal_n++;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic ck(input logic [79:0] g, input logic [79:0] e, input string s);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t %s got %h want %h", $time, s, g, e);
        end
    endtask

    // Legal random word per address; reserved bits stay zero.
    function automatic logic [26:0] mk(input logic [3:0] a);
        logic [31:0] x, y;
        logic [20:0] md;
        x = rnd();
        y = rnd();
        // Numerators stay below 2^20 and moduli at or above it, so any pair is legal.
        md = {1'b1, x[19:0]};
        case (a)
            4'h1: mk = {2'b00, y[3:0], 1'b0, y[23:4]};
            4'h2: mk = {5'h00, m[1][24] ? y[0] : 1'b1, md};
            4'h3: mk = {2'b00, y[11:0], 13'(1 + x % 8191)};
            4'h4: mk = 27'(y & 32'h000b9f7f) | 27'h100;
            default: mk = 27'(y & 32'h0039ffff);
        endcase
    endfunction

    task automatic rst();
        sys_rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        foreach (m[i]) m[i] = RESET_DATA;
        pend = '0;
        locked = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Write frame plus the model's view of shadowing and calibration.
    task automatic wr(input logic [3:0] a, input logic [26:0] d);
        logic [26:0] rd;
        host.frame({1'b0, a, d}, 32, rd);
        if (a >= 4'h1 && a <= 4'h3 && d[26]) begin
            sh[a] = d;
            pend[a] = 1'b1;
        end else if (a <= 4'h4) begin
            m[a] = d;
        end
        if (a == 4'h0) begin
            for (int i = 1; i < 4; i++) begin
                if (pend[i]) m[i] = sh[i];
            end
            pend = '0;
            if (!m[1][23] && !m[3][25]) cal_exp++;
        end
        if (m[3][25]) locked = 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [26:0] e);
        logic [26:0] rd;
        host.frame({1'b1, a, 27'h0}, 32, rd);
        ck(rd, e, "read");
    endtask

    task automatic tick(input int n, input logic [3:0] err);
        repeat (n) begin
            pfd_tick = 1'b1;
            phase_err_ns = err;
            @(posedge clk);
            #1;
            pfd_tick = 1'b0;
            @(posedge clk);
            #1;
        end
    endtask

    // Compares ctrl, the enables, the lock indicator and the calibration count with the model.
    task automatic cmp();
        psc_ctrl_t e;
        logic p, mu;
        logic [6:0] ev;
        e = {m[1][20:0], m[2][20:0], m[3][12:0], m[3][14:13], m[4][9:8],
            10'(m[3][23:19] * (m[3][24] ? 20 : 10)), m[3][18], m[0][20:19], m[3][16:15] == 2'b01,
            m[3][16:15] == 2'b10, m[1][22], m[1][21], m[4][17:15], m[4][12]};
        // With down-split off there is no split current at all.
        if (!m[3][17]) e.split_level = 2'b00;
        ck(ctrl, e, "ctrl");
        p = m[3][25];
        mu = m[4][7] && !locked;
        ev = {!p && !m[1][24] && !mu, !p && !m[2][21] && !mu, p, !p && !m[1][23], !p && !m[4][19],
            !p && m[4][19], !p && m[3][17]};
        ck({en[7:2], en[0]}, ev, "enables");
        if (!p) ck(en[1], !m[4][11], "gain");
        ck(lk, locked ^ m[4][6], "lock");
        ck(cal_n, cal_exp, "cal");
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        logic [26:0] d, rd;
        int w;
        rst();
        cmp();
        rdchk(4'h1, RESET_DATA);
        $display("reset test done");
        repeat (4) begin
            for (int a = 1; a < 5; a++) wr(4'(a), mk(4'(a)));
            wr(4'h0, mk(4'h0));
            cmp();
            for (int a = 1; a < 5; a++) rdchk(4'(a), m[a]);
        end
        $display("random write test done");
        for (int a = 1; a < 4; a++) begin
            d = mk(4'(a)) | 27'h4000000;
            if (a == 1) d[23] = m[1][23];
            // The first output may come up enabled, so the second stays off.
            if (a == 2) d[21] = 1'b1;
            wr(4'(a), d);
        end
        wr(4'h4, mk(4'h4));
        cmp();
        wr(4'h0, mk(4'h0));
        cmp();
        $display("shadow test done");
        for (int c = 0; c < 4; c++) begin
            d = m[3];
            d[26:13] = {2'b00, c[0], 5'h1f, c[1], 1'b1, 2'(c), 2'(c)};
            wr(4'h3, d);
            cmp();
        end
        wr(4'h9, 27'h1fffff);
        host.frame({5'h01, 27'h1fffff}, 31, rd);
        cmp();
        rdchk(4'h5, 27'h0);
        $display("decode test done");
        for (int c = 0; c < 8; c++) begin
            rst();
            w = int'(rnd() % 7);
            d = 27'h180;
            d[6] = c[0];
            d[5:3] = 3'(w);
            d[2:0] = 3'(c);
            wr(4'h4, d);
            if (c == 1) begin
                tick(tg[c] - 1, 4'((w + 1) * 2));
                tick(1, 4'((w + 1) * 2 + 1));
            end
            tick(tg[c] - 1, 4'((w + 1) * 2));
            cmp();
            tick(2, 4'((w + 1) * 2));
            locked = 1'b1;
            cmp();
        end
        $display("lock test done");
        wr(4'h3, 27'h2000000);
        cmp();
        wr(4'h3, 27'h0);
        cmp();
        $display("power down test done");
        stop_test();
    end
endmodule

`default_nettype wire
